// ==== wio_gen_consts.svh ====
// constants of the waveform io generator
// Functional notes
// - eight output lines exist and each one is controlled on its own.
// - the waveform generator advances only while its gateable clock enable is high, to save power when unused.
// - a line can toggle every master clock cycle, i.e. at half the master clock rate.
// - a set or clear write changes the line level in the cycle right after the write.
// - per-line waveform descriptions are written first and a separate start command runs them.
// - after start the waveforms run on their own, timed only by the clock.
// - when enabled, the end of a line's waveform raises an event to both the mcu and the host.
// - each line can be turned into a high-impedance input with its driver off.
// - the pad level of each line is mirrored continuously in its own status bit.
// - both the host and the mcu can set and clear line levels and program waveforms.
// - all eight lines stay usable for other purposes when actuator control goes elsewhere.
// - input sampling per line is enabled by configuration and the sampled state is readable.
`ifndef WIO_GEN_CONSTS_SVH
`define WIO_GEN_CONSTS_SVH
`define WIO_LINES   8
`define WIO_LINE_W  3
`define WIO_CNT_W   16
`define WIO_REP_W   8
`define WIO_CNT_ONE 16'h0001
`define WIO_REP_ONE 8'h01
`define WIO_REP_INF 8'h00
`define WIO_LINE_RST 8'h00
`define WIO_ALL_IN  8'hff
`endif

// ==== wio_gen_pkg.sv ====
// types of the waveform io generator
`include "wio_gen_consts.svh"
package wio_gen_pkg;
  typedef enum logic [0:0] {WIO_IDLE = 1'h0, WIO_RUN = 1'h1} wio_gen_t;
  typedef struct packed {
    wio_gen_t                                  gen;
    logic [`WIO_LINES-1:0]                     level;
    logic [`WIO_LINES-1:0]                     armed;
    logic [`WIO_LINES-1:0]                     phase;
    logic [`WIO_LINES-1:0]                     done;
    logic [`WIO_LINES-1:0]                     syncA;
    logic [`WIO_LINES-1:0]                     syncB;
    logic [`WIO_LINES-1:0]                     sampled;
    logic [`WIO_LINES-1:0]                     enN;
    logic [`WIO_LINES-1:0]                     out;
    logic                                      evtMcu;
    logic                                      evtHost;
    logic [`WIO_LINES-1:0][`WIO_CNT_W-1:0]     hiLen;
    logic [`WIO_LINES-1:0][`WIO_CNT_W-1:0]     loLen;
    logic [`WIO_LINES-1:0][`WIO_CNT_W-1:0]     cnt;
    logic [`WIO_LINES-1:0][`WIO_REP_W-1:0]     reps;
    logic [`WIO_LINES-1:0][`WIO_REP_W-1:0]     left;
  } wio_state_t;
endpackage

// ==== wio_gen.sv ====
// waveform io unit: direct line control, waveform generation and pad sampling
`timescale 1ns/1ps
`include "wio_gen_consts.svh"
module wio_gen (
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  input  wire logic                   unitEnable,
  input  wire logic                   hostWr,
  input  wire logic [`WIO_LINES-1:0]  hostSet,
  input  wire logic [`WIO_LINES-1:0]  hostClr,
  input  wire logic                   mcuWr,
  input  wire logic [`WIO_LINES-1:0]  mcuSet,
  input  wire logic [`WIO_LINES-1:0]  mcuClr,
  input  wire logic [`WIO_LINES-1:0]  inputMode,
  input  wire logic [`WIO_LINES-1:0]  sampleEnable,
  input  wire logic                   wfWrite,
  input  wire logic [`WIO_LINE_W-1:0] wfLine,
  input  wire logic                   wfArm,
  input  wire logic [`WIO_CNT_W-1:0]  wfHighLen,
  input  wire logic [`WIO_CNT_W-1:0]  wfLowLen,
  input  wire logic [`WIO_REP_W-1:0]  wfRepeats,
  input  wire logic                   startCmd,
  input  wire logic                   stopCmd,
  input  wire logic [`WIO_LINES-1:0]  notifyEnable,
  input  wire logic [`WIO_LINES-1:0]  padIn,
  output logic      [`WIO_LINES-1:0]  lineOut,
  output logic      [`WIO_LINES-1:0]  lineOutEnN,
  output logic      [`WIO_LINES-1:0]  inputState,
  output logic      [`WIO_LINES-1:0]  sampledState,
  output logic      [`WIO_LINES-1:0]  doneFlags,
  output logic                        genBusy,
  output logic                        eventMcu,
  output logic                        eventHost
);

  wio_gen_pkg::wio_state_t s_reg;
  wio_gen_pkg::wio_state_t s_next;

  // a zero length would never elapse; it is taken as one cycle, the fastest toggle
  // one-cycle minimum half
  function automatic logic [`WIO_CNT_W-1:0] minLen(input logic [`WIO_CNT_W-1:0] len);
    minLen = (len == '0) ? `WIO_CNT_ONE : len;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [`WIO_LINES-1:0] setBits;
    logic [`WIO_LINES-1:0] clrBits;
    logic [`WIO_LINES-1:0] newDone;
    setBits = '0;
    clrBits = '0;
    newDone = '0;
    s_next = s_reg;

    s_next.syncA = padIn;
    s_next.syncB = s_reg.syncA;

    for (int i = 0; i < `WIO_LINES; i++) begin
      if (sampleEnable[i]) begin
        s_next.sampled[i] = s_reg.syncB[i];
      end
    end

    s_next.enN = inputMode;

    if (hostWr) begin
      setBits = setBits | hostSet;
      clrBits = clrBits | hostClr;
    end
    if (mcuWr) begin
      setBits = setBits | mcuSet;
      clrBits = clrBits | mcuClr;
    end
    s_next.level = (s_reg.level & ~clrBits) | setBits;

    if (wfWrite) begin
      s_next.hiLen[wfLine] = minLen(wfHighLen);
      s_next.loLen[wfLine] = minLen(wfLowLen);
      s_next.reps[wfLine]  = wfRepeats;
      s_next.armed[wfLine] = wfArm;
    end

    if (s_reg.gen == wio_gen_pkg::WIO_RUN && unitEnable) begin
      for (int i = 0; i < `WIO_LINES; i++) begin
        if (s_reg.armed[i] && !s_reg.done[i]) begin
          if (s_reg.cnt[i] > `WIO_CNT_ONE) begin
            s_next.cnt[i] = s_reg.cnt[i] - `WIO_CNT_ONE;
          end else if (s_reg.phase[i]) begin
            s_next.phase[i] = 1'h0;
            s_next.cnt[i]   = s_reg.loLen[i];
          end else if (s_reg.left[i] == `WIO_REP_ONE) begin
            s_next.done[i] = 1'h1;
            newDone[i]     = 1'h1;
          end else begin
            // zero repeats means run until stopped
            if (s_reg.left[i] != `WIO_REP_INF) begin
              s_next.left[i] = s_reg.left[i] - `WIO_REP_ONE;
            end
            s_next.phase[i] = 1'h1;
            s_next.cnt[i]   = s_reg.hiLen[i];
          end
        end
      end
      if ((s_next.done & s_reg.armed) == s_reg.armed) begin
        s_next.gen = wio_gen_pkg::WIO_IDLE;
      end
    end

    if (startCmd && s_reg.gen == wio_gen_pkg::WIO_IDLE && s_reg.armed != '0) begin
      s_next.gen = wio_gen_pkg::WIO_RUN;
      for (int i = 0; i < `WIO_LINES; i++) begin
        s_next.phase[i] = 1'h1;
        s_next.cnt[i]   = s_reg.hiLen[i];
        s_next.left[i]  = s_reg.reps[i];
        s_next.done[i]  = 1'h0;
      end
    end
    if (stopCmd) begin
      s_next.gen = wio_gen_pkg::WIO_IDLE;
    end

    // end of waveform notifies both masters
    s_next.evtMcu  = |(newDone & notifyEnable);
    s_next.evtHost = |(newDone & notifyEnable);

    for (int i = 0; i < `WIO_LINES; i++) begin
      if (s_next.enN[i]) begin
        s_next.out[i] = 1'h0;
      end else if (s_next.gen == wio_gen_pkg::WIO_RUN && s_next.armed[i]
                   && !s_next.done[i]) begin
        s_next.out[i] = s_next.phase[i];
      end else begin
        s_next.out[i] = s_next.level[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_reg       <= '0;
      s_reg.enN   <= `WIO_ALL_IN;
      s_reg.level <= `WIO_LINE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lineOut      = s_reg.out;
  assign lineOutEnN   = s_reg.enN;
  assign inputState   = s_reg.syncB;
  assign sampledState = s_reg.sampled;
  assign doneFlags    = s_reg.done;
  assign genBusy      = s_reg.gen;
  assign eventMcu     = s_reg.evtMcu;
  assign eventHost    = s_reg.evtHost;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence seqStart;
    startCmd && !stopCmd && !genBusy && s_reg.armed != '0;
  endsequence

  sequence seqRunHold;
    genBusy && unitEnable && !stopCmd && s_reg.armed[2] && !s_reg.done[2]
      && s_reg.cnt[2] > `WIO_CNT_ONE;
  endsequence

  a_direct_set_line: assert property (
    (hostWr && hostSet[0] && !inputMode[0] && !genBusy && !startCmd) |=> lineOut[0])
    else $error("direct set did not reach line 0");

  a_input_hiz_line: assert property (
    inputMode[3] |=> (lineOutEnN[3] && !lineOut[3]))
    else $error("input line still driven");

  a_pad_mirror_delay: assert property (
    ##2 (inputState == $past(padIn, 2)))
    else $error("pad mirror not two cycles behind pad");

  a_sample_hold_off: assert property (
    !sampleEnable[1] |=> $stable(sampledState[1]))
    else $error("sampled state changed while sampling off");

  a_start_runs_gen: assert property (
    seqStart |=> genBusy ##0 (doneFlags == '0))
    else $error("start did not launch generation");

  a_half_period_hold: assert property (
    seqRunHold |=> $stable(s_reg.phase[2]))
    else $error("line toggled before its half period ended");

  a_gate_freeze_cnt: assert property (
    (!unitEnable && genBusy && !stopCmd && !startCmd) |=> $stable(s_reg.cnt))
    else $error("counters moved while unit clock gated");

  a_event_both_masters: assert property (
    eventMcu |-> (eventHost
      && (doneFlags & ~$past(doneFlags) & $past(notifyEnable)) != '0))
    else $error("event not raised to both masters");

  a_stop_idles_gen: assert property (
    stopCmd |=> !genBusy ##1 ($past(startCmd) || !genBusy))
    else $error("generator kept running after stop");

  a_mcu_clear_line: assert property (
    (mcuWr && mcuClr[2] && !(hostWr && hostSet[2]) && !mcuSet[2] && !genBusy
      && !startCmd) |=> !lineOut[2])
    else $error("mcu clear did not reach line 2");

endmodule

// ==== wio_gen_actuator.sv ====
// actuator or flash driver model on the far side of the eight lines
`timescale 1ns/1ps
`include "wio_gen_consts.svh"
module wio_gen_actuator (
  input  wire logic [`WIO_LINES-1:0] lineOut,
  input  wire logic [`WIO_LINES-1:0] lineOutEnN,
  input  wire logic [`WIO_LINES-1:0] feedback,
  output logic      [`WIO_LINES-1:0] padIn
);
  // pad resolution: a driven pad shows the unit, a released one the feedback
  assign padIn = (lineOut & ~lineOutEnN) | (feedback & lineOutEnN);
endmodule

// ==== tb_wio_gen.sv ====
// self-checking bench of the waveform io unit
`timescale 1ns/1ps
`include "wio_gen_consts.svh"
module tb_wio_gen;
  logic        sys_clk, reset, unitEnable, hostWr, mcuWr, wfWrite, wfArm, startCmd, stopCmd;
  logic [7:0]  hostSet, hostClr, mcuSet, mcuClr, inputMode, sampleEnable, notifyEnable;
  logic [7:0]  padIn, feedback, lineOut, lineOutEnN, inputState, sampledState, doneFlags;
  logic        genBusy, eventMcu, eventHost;
  logic [2:0]  wfLine;
  logic [15:0] wfHighLen, wfLowLen;
  logic [7:0]  wfRepeats;
  int          failures = 0;
  int          checked = 0;

  wio_gen u_wio_gen (.sys_clk(sys_clk), .reset(reset), .unitEnable(unitEnable),
    .hostWr(hostWr), .hostSet(hostSet), .hostClr(hostClr), .mcuWr(mcuWr), .mcuSet(mcuSet),
    .mcuClr(mcuClr), .inputMode(inputMode), .sampleEnable(sampleEnable), .wfWrite(wfWrite),
    .wfLine(wfLine), .wfArm(wfArm), .wfHighLen(wfHighLen), .wfLowLen(wfLowLen),
    .wfRepeats(wfRepeats), .startCmd(startCmd), .stopCmd(stopCmd),
    .notifyEnable(notifyEnable), .padIn(padIn), .lineOut(lineOut), .lineOutEnN(lineOutEnN),
    .inputState(inputState), .sampledState(sampledState), .doneFlags(doneFlags),
    .genBusy(genBusy), .eventMcu(eventMcu), .eventHost(eventHost));
  wio_gen_actuator u_wio_gen_actuator (.lineOut(lineOut), .lineOutEnN(lineOutEnN),
    .feedback(feedback), .padIn(padIn));

  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // strobe is lowered for a full cycle so back-to-back calls never re-drive it in one step
  task automatic dwr(input logic mcu, input logic [7:0] s, input logic [7:0] c);
    {hostWr, hostSet, hostClr} = {~mcu, s, c};
    {mcuWr, mcuSet, mcuClr} = {mcu, s, c};
    tick(1);
    {hostWr, mcuWr} = 2'h0;
    tick(1);
  endtask
  task automatic wf(input logic [2:0] ln, input logic [15:0] hi, input logic [15:0] lo,
                    input logic [7:0] rp, input logic arm);
    {wfWrite, wfLine, wfHighLen, wfLowLen, wfRepeats, wfArm} = {1'h1, ln, hi, lo, rp, arm};
    tick(1);
    wfWrite = 1'h0;
    tick(1);
  endtask
  task automatic pulse_start();
    startCmd = 1'h1;
    tick(1);
    startCmd = 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(8 * 3000);
    failures++;
    complete_run();
  end
  initial begin
    {hostWr, mcuWr, wfWrite, wfArm, startCmd, stopCmd} = 6'h00;
    {hostSet, hostClr, mcuSet, mcuClr} = 32'h0;
    {inputMode, sampleEnable, notifyEnable, feedback} = 32'h0;
    {wfLine, wfHighLen, wfLowLen, wfRepeats} = 43'h0;
    unitEnable = 1'h1;
    reset = 1'h1;
    tick(12);
    chk({lineOut, lineOutEnN}, 16'h00ff);
    reset = 1'h0;
    tick(2);
    chk(lineOutEnN, 8'h00);
    dwr(1'h0, 8'h81, 8'h00);
    chk(lineOut, 8'h81);
    dwr(1'h1, 8'h06, 8'h01);
    chk(lineOut, 8'h86);
    dwr(1'h0, 8'h10, 8'h90);
    chk(lineOut, 8'h16);
    tick(2);
    chk(inputState, 8'h16);
    chk(sampledState, 8'h00);
    // line three released as an input
    inputMode = 8'h08;
    feedback = 8'h08;
    tick(1);
    chk(lineOutEnN, 8'h08);
    sampleEnable = 8'hff;
    tick(1);
    // the new pad level is still inside the two-flop synchroniser here
    chk(inputState, 8'h16);
    tick(3);
    chk({inputState, sampledState}, 16'h1e1e);
    {sampleEnable, feedback} = 16'h0000;
    tick(4);
    chk({inputState, sampledState}, 16'h161e);
    dwr(1'h0, 8'h08, 8'h00);
    chk(lineOut, 8'h16);
    inputMode = 8'h00;
    dwr(1'h1, 8'h00, 8'hff);
    // one period at full rate with notification
    notifyEnable = 8'h01;
    wf(3'h0, 16'h0001, 16'h0001, 8'h01, 1'h1);
    chk({genBusy, lineOut}, 16'h0000);
    pulse_start();
    chk({genBusy, lineOut}, 16'h0101);
    tick(1);
    chk(lineOut, 8'h00);
    tick(1);
    chk({doneFlags, genBusy, eventMcu, eventHost}, 16'h000b);
    tick(1);
    chk({eventMcu, eventHost}, 16'h0000);
    // endless waveform frozen by the gate, then stopped
    notifyEnable = 8'h00;
    wf(3'h0, 16'h0001, 16'h0001, 8'h01, 1'h0);
    wf(3'h2, 16'h0002, 16'h0001, 8'h00, 1'h1);
    pulse_start();
    chk({doneFlags, genBusy, lineOut}, 16'h0104);
    tick(1);
    chk(lineOut, 8'h04);
    tick(1);
    chk(lineOut, 8'h00);
    unitEnable = 1'h0;
    tick(3);
    chk({genBusy, lineOut}, 16'h0100);
    unitEnable = 1'h1;
    tick(1);
    chk(lineOut, 8'h04);
    stopCmd = 1'h1;
    tick(1);
    stopCmd = 1'h0;
    chk({doneFlags, genBusy, eventMcu}, 16'h0000);
    // two periods on line one with notification off
    wf(3'h2, 16'h0001, 16'h0001, 8'h01, 1'h0);
    wf(3'h1, 16'h0001, 16'h0001, 8'h02, 1'h1);
    pulse_start();
    chk(lineOut, 8'h02);
    tick(2);
    chk(lineOut, 8'h02);
    tick(2);
    chk({doneFlags, genBusy, eventMcu}, 16'h0008);
    // all eight lines under direct control
    dwr(1'h0, 8'hff, 8'h00);
    chk(lineOut, 8'hff);
    complete_run();
  end
endmodule
